//--- hdl/pci_target_command_backend_ctrl.sv
// PCI target control: claim, data phases, retry, disconnect, abort.
// Assumes bus pins and backend signals are on the bus clock.
`timescale 1ns/1ps
`default_nettype none
module pci_target_command_backend_ctrl (
  input wire logic clk_sys, // PCI bus clock
  input wire logic resetn, // Async reset, low
  input wire pci_tgt_pkg::bus_in_t bus_in, // Bus pin inputs
  input wire logic mem_space_en, // Memory decode enable
  input wire logic io_space_en, // I/O decode enable
  input wire logic int_enable, // Interrupts enabled
  input wire logic [31:0] mem_base, // Memory window base
  input wire logic [31:0] io_base, // I/O window base
  input wire logic initiator_active, // Device is initiator
  input wire logic backend_busy, // Backend cannot go on
  input wire logic backend_error, // Backend asks abort
  input wire logic backend_write_ready, // Backend takes data
  input wire logic backend_read_ready, // Backend has data
  input wire logic [31:0] rd_data, // Read data from backend
  input wire logic backend_irq_in_low, // Backend interrupt, low
  input wire logic dma_reg_select_low, // DMA register select
  input wire logic dma_reg_read_low, // DMA register read
  input wire logic dma_reg_write_low, // DMA register write
  input wire logic [1:0] dma_reg_index, // DMA register index
  input wire logic [3:0] initiator_lane_enables_lo, // Lower lanes
  input wire logic [3:0] initiator_lane_enables_hi, // Upper lanes
  output var pci_tgt_pkg::tgt_ctl_t ctl_out, // Target control pins
  output logic ctl_oe, // Drive control pins
  output logic [31:0] ad_out, // Read data to bus
  output logic ad_oe, // Drive data lines
  output logic inta_out, // Interrupt pin level
  output logic inta_oe, // Interrupt pin pulled
  output logic datapath_begin, // Cycle start pulse
  output logic datapath_end, // Cycle end pulse
  output var pci_tgt_pkg::cycle_qual_t cycle_qual, // Per-cycle info
  output logic [31:0] beat_addr, // Address of this beat
  output logic [31:0] wr_data, // Write data to backend
  output logic [3:0] wr_lane_strobe, // Write lane strobes
  output logic rd_taken, // Read beat consumed
  output var pci_tgt_pkg::dma_reg_req_t dma_req, // DMA access
  output logic [7:0] initiator_cbe_n // Initiator lanes
);
  import pci_tgt_pkg::*;

  tgt_state_t state_q;
  tgt_ctl_t ctl_q;
  cycle_qual_t qual_d;
  cycle_qual_t qual_q;
  dma_reg_req_t dma_q;
  logic hit;
  logic frame_prev_q;
  logic ctl_oe_q;
  logic begin_q;
  logic end_q;
  logic data_seen_q;
  logic [4:0] wait_q;
  logic [31:0] beat_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_lane_q;
  logic [31:0] ad_out_q;
  logic ad_oe_q;
  logic rd_taken_q;
  logic inta_oe_q;
  logic [7:0] cbe_q;
  logic addr_phase;
  logic claim;
  logic busy_eff;
  logic err_eff;
  logic ready;
  logic xfer;
  logic can_move;
  logic last;
  logic timeout;
  logic leaving;
  logic [4:0] wait_lim;

  tgt_cmd_decode u_decode (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cmd(bus_in.cbe_n),
    .addr(bus_in.ad),
    .idsel(bus_in.idsel),
    .mem_space_en(mem_space_en),
    .io_space_en(io_space_en),
    .mem_base(mem_base),
    .io_base(io_base),
    .hit(hit),
    .qual(qual_d)
  );

  tgt_backend_side u_side (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .int_enable(int_enable),
    .backend_irq_in_low(backend_irq_in_low),
    .dma_reg_select_low(dma_reg_select_low),
    .dma_reg_read_low(dma_reg_read_low),
    .dma_reg_write_low(dma_reg_write_low),
    .dma_reg_index(dma_reg_index),
    .initiator_active(initiator_active),
    .initiator_lane_enables_lo(initiator_lane_enables_lo),
    .initiator_lane_enables_hi(initiator_lane_enables_hi),
    .inta_oe_q(inta_oe_q),
    .dma_req_q(dma_q),
    .initiator_cbe_n_q(cbe_q)
  );

  // Address phase is the first clock of FRAME low; own cycles skipped
  always_comb begin
    addr_phase = !bus_in.frame_n && frame_prev_q &&
                 (state_q == st_idle) && !initiator_active;
    claim = addr_phase && hit;
    busy_eff = backend_busy && !initiator_active;
    err_eff = backend_error && !initiator_active;
    ready = qual_q.is_read ? backend_read_ready : backend_write_ready;
    xfer = (state_q == st_data) && !ctl_q.trdy_n && !bus_in.irdy_n;
    // Once TRDY is out it must stay until the beat moves
    can_move = ctl_q.trdy_n || xfer;
    last = xfer && bus_in.frame_n;
    wait_lim = data_seen_q ? next_wait_limit : init_wait_limit;
    timeout = (wait_q >= wait_lim) && !xfer;
    leaving = ((state_q == st_data) && last) ||
              ((state_q == st_term) && bus_in.frame_n);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frame_prev_q <= 1'b1;
    end else begin
      frame_prev_q <= bus_in.frame_n;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= st_idle;
      ctl_q <= '1;
    end else begin
      case (state_q)
        st_idle: begin
          if (claim) begin
            state_q <= st_claim;
            ctl_q.devsel_n <= 1'b0;
          end
        end
        st_claim: begin
          if (err_eff) begin
            state_q <= st_term;
            ctl_q.devsel_n <= 1'b1;
            ctl_q.stop_n <= 1'b0;
          end else if (busy_eff) begin
            state_q <= st_term;
            ctl_q.stop_n <= 1'b0;
          end else begin
            state_q <= st_data;
            ctl_q.trdy_n <= ~ready;
          end
        end
        st_data: begin
          if (last) begin
            state_q <= st_idle;
            ctl_q <= '1;
          end else if (!can_move) begin
            state_q <= st_data;
          end else if (err_eff) begin
            state_q <= st_term;
            ctl_q.devsel_n <= 1'b1;
            ctl_q.trdy_n <= 1'b1;
            ctl_q.stop_n <= 1'b0;
          end else if (busy_eff || timeout) begin
            // Disconnect without data; with none moved it reads as a retry
            state_q <= st_term;
            ctl_q.trdy_n <= 1'b1;
            ctl_q.stop_n <= 1'b0;
          end else begin
            ctl_q.trdy_n <= ~ready;
          end
        end
        st_term: begin
          if (bus_in.frame_n) begin
            state_q <= st_idle;
            ctl_q <= '1;
          end
        end
        default: begin
          state_q <= st_idle;
          ctl_q <= '1;
        end
      endcase
    end
  end

  // Pins stay driven high one clock after release, then float
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctl_oe_q <= 1'b0;
    end else begin
      ctl_oe_q <= claim || (state_q != st_idle);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      begin_q <= 1'b0;
      end_q <= 1'b0;
      qual_q <= '0;
    end else begin
      begin_q <= claim;
      end_q <= leaving;
      if (claim) begin
        qual_q <= qual_d;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wait_q <= '0;
    end else if ((state_q != st_data) || xfer) begin
      wait_q <= '0;
    end else if (ctl_q.trdy_n && (wait_q != '1)) begin
      wait_q <= wait_q + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      data_seen_q <= 1'b0;
      beat_addr_q <= '0;
    end else if (claim) begin
      data_seen_q <= 1'b0;
      beat_addr_q <= bus_in.ad;
    end else if (xfer) begin
      data_seen_q <= 1'b1;
      beat_addr_q <= beat_addr_q + beat_step;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_data_q <= '0;
      wr_lane_q <= lanes_off;
    end else if (xfer && !qual_q.is_read) begin
      wr_data_q <= bus_in.ad;
      wr_lane_q <= ~bus_in.cbe_n;
    end else begin
      wr_lane_q <= lanes_off;
    end
  end

  // Read data follows the backend until TRDY is out, then holds
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ad_out_q <= '0;
      ad_oe_q <= 1'b0;
      rd_taken_q <= 1'b0;
    end else begin
      if (can_move) begin
        ad_out_q <= rd_data;
      end
      ad_oe_q <= qual_q.is_read && !leaving &&
                 ((state_q == st_claim) || (state_q == st_data));
      rd_taken_q <= xfer && qual_q.is_read;
    end
  end

  assign ctl_out = ctl_q;
  assign ctl_oe = ctl_oe_q;
  assign ad_out = ad_out_q;
  assign ad_oe = ad_oe_q;
  assign inta_out = 1'b0;
  assign inta_oe = inta_oe_q;
  assign datapath_begin = begin_q;
  assign datapath_end = end_q;
  assign cycle_qual = qual_q;
  assign beat_addr = beat_addr_q;
  assign wr_data = wr_data_q;
  assign wr_lane_strobe = wr_lane_q;
  assign rd_taken = rd_taken_q;
  assign dma_req = dma_q;
  assign initiator_cbe_n = cbe_q;

  chk_retry_start:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == st_claim && busy_eff && !err_eff)
      |=> (!ctl_q.stop_n && ctl_q.trdy_n && !ctl_q.devsel_n && !rd_taken))
    else $error("No retry on busy at start");

  chk_disc_busy:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == st_data && data_seen_q && can_move && !last && busy_eff && !err_eff)
      |=> (!ctl_q.stop_n && ctl_q.trdy_n && !ctl_q.devsel_n))
    else $error("No disconnect on late busy");

  chk_busy_master:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == st_claim && initiator_active && !backend_error)
      |=> ctl_q.stop_n)
    else $error("Busy acted as initiator");

  chk_qual_stable:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    (datapath_begin ##1 !datapath_end) |-> $stable(cycle_qual))
    else $error("Qualifiers moved inside cycle");

  chk_claim_begin:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    claim |=> (datapath_begin && !ctl_q.devsel_n && ctl_oe
               && cycle_qual == $past(qual_d)))
    else $error("Claim not signalled");

  chk_write_lanes:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    (xfer && !qual_q.is_read)
      |=> (wr_lane_strobe == ~$past(bus_in.cbe_n) && wr_data == $past(bus_in.ad)))
    else $error("Write lanes not taken");

  chk_abort:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    (((state_q == st_claim) || (state_q == st_data && can_move && !last)) && err_eff)
      |=> (ctl_q.devsel_n && !ctl_q.stop_n) ##1 (ctl_q.devsel_n))
    else $error("No target abort on error");

  chk_wait_limit:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == st_data && !data_seen_q && ctl_q.trdy_n && !err_eff)[*8]
      |-> ##[1:10] (!ctl_q.stop_n || state_q != st_data))
    else $error("No disconnect on slow backend");

  chk_miss_release:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    (addr_phase && !hit) |=> (ctl_q.devsel_n && state_q == st_idle))
    else $error("Miss was claimed");

  chk_single_end:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    last |=> (datapath_end && ctl_q.trdy_n && state_q == st_idle))
    else $error("Last beat did not end cycle");
endmodule // pci_target_command_backend_ctrl
`default_nettype wire

//--- hdl/pci_tgt_pkg.sv
// Constants, states and carriers for the PCI target control block.
// Assumes one clock domain: the PCI bus clock.
package pci_tgt_pkg;
  localparam logic [3:0] cmd_io_rd = 4'h2;
  localparam logic [3:0] cmd_io_wr = 4'h3;
  localparam logic [3:0] cmd_mem_rd = 4'h6;
  localparam logic [3:0] cmd_mem_wr = 4'h7;
  localparam logic [3:0] cmd_cfg_rd = 4'hA;
  localparam logic [3:0] cmd_cfg_wr = 4'hB;
  localparam logic [3:0] cmd_mem_rd_mult = 4'hC;
  localparam logic [3:0] cmd_mem_rd_line = 4'hE;
  // Build option: clear to strip I/O decode and both I/O commands
  localparam logic io_decode_on = 1'b1;
  localparam int io_win_bits = 8;
  // 4 MB window for the 32-bit build; 23 gives the 8 MB 64-bit build
  localparam int mem_window_bits = 22;
  localparam int cfg_idx_lsb = 2;
  localparam int cfg_idx_msb = 7;
  localparam logic [1:0] cfg_type0 = 2'h0;
  // Target latency limits of the bus, in clocks
  localparam logic [4:0] init_wait_limit = 5'h10;
  localparam logic [4:0] next_wait_limit = 5'h08;
  localparam logic [31:0] beat_step = 32'h0000_0004;
  localparam logic [3:0] lanes_off = 4'h0;
  localparam logic [7:0] cbe_idle = 8'hFF;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_claim = 2'b01,
    st_data = 2'b11,
    st_term = 2'b10
  } tgt_state_t;

  typedef struct packed {
    logic frame_n;
    logic irdy_n;
    logic idsel;
    logic [3:0] cbe_n;
    logic [31:0] ad;
  } bus_in_t;

  typedef struct packed {
    logic devsel_n;
    logic trdy_n;
    logic stop_n;
  } tgt_ctl_t;

  typedef struct packed {
    logic is_read;
    logic is_cfg;
    logic is_io;
    logic [5:0] cfg_index;
    logic [31:0] addr;
  } cycle_qual_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] index;
  } dma_reg_req_t;
endpackage

//--- hdl/tgt_cmd_decode.sv
// Command and address decode of one address phase.
// Assumes cmd and addr are the bus values of the address phase.
`timescale 1ns/1ps
`default_nettype none
module tgt_cmd_decode (
  input wire logic clk_sys, // Bus clock, for checks
  input wire logic resetn, // Async reset, low
  input wire logic [3:0] cmd, // Command lanes, decoded
  input wire logic [31:0] addr, // Address phase value
  input wire logic idsel, // Config select
  input wire logic mem_space_en, // Memory decode enable
  input wire logic io_space_en, // I/O decode enable
  input wire logic [31:0] mem_base, // Memory window base
  input wire logic [31:0] io_base, // I/O window base
  output logic hit, // Claim this cycle
  output var pci_tgt_pkg::cycle_qual_t qual // Cycle qualifiers
);
  import pci_tgt_pkg::*;
  logic mem_cmd;
  logic io_cmd;
  logic cfg_cmd;
  logic mem_hit;
  logic io_hit;
  logic cfg_hit;

  always_comb begin
    mem_cmd = (cmd == cmd_mem_rd) || (cmd == cmd_mem_wr) ||
              (cmd == cmd_mem_rd_mult) || (cmd == cmd_mem_rd_line);
    io_cmd = io_decode_on && ((cmd == cmd_io_rd) || (cmd == cmd_io_wr));
    cfg_cmd = (cmd == cmd_cfg_rd) || (cmd == cmd_cfg_wr);
    mem_hit = mem_cmd && mem_space_en &&
              (addr[31:mem_window_bits] == mem_base[31:mem_window_bits]);
    io_hit = io_cmd && io_space_en &&
             (addr[31:io_win_bits] == io_base[31:io_win_bits]);
    cfg_hit = cfg_cmd && idsel && (addr[1:0] == cfg_type0);
    hit = mem_hit || io_hit || cfg_hit;
    qual.is_read = ~cmd[0];
    qual.is_cfg = cfg_hit;
    qual.is_io = io_hit;
    qual.cfg_index = addr[cfg_idx_msb:cfg_idx_lsb];
    qual.addr = addr;
  end

  chk_unsup_no_claim:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    (cmd inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hD, 4'hF}) |-> !hit)
    else $error("Unsupported command claimed");

  chk_cfg_select:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    (cfg_cmd && (!idsel || addr[1:0] != cfg_type0)) |-> !hit)
    else $error("Config claimed without select");
endmodule // tgt_cmd_decode
`default_nettype wire

//--- hdl/tgt_backend_side.sv
// Interrupt pin drive, DMA register port and initiator lane enables.
// Assumes all backend inputs are made on the bus clock.
`timescale 1ns/1ps
`default_nettype none
module tgt_backend_side (
  input wire logic clk_sys, // Bus clock
  input wire logic resetn, // Async reset, low
  input wire logic int_enable, // Interrupts enabled
  input wire logic backend_irq_in_low, // Backend interrupt, low
  input wire logic dma_reg_select_low, // DMA register select
  input wire logic dma_reg_read_low, // DMA register read
  input wire logic dma_reg_write_low, // DMA register write
  input wire logic [1:0] dma_reg_index, // DMA register index
  input wire logic initiator_active, // Device is initiator
  input wire logic [3:0] initiator_lane_enables_lo, // Lower lanes, low
  input wire logic [3:0] initiator_lane_enables_hi, // Upper lanes, low
  output logic inta_oe_q, // Interrupt pin pulled low
  output var pci_tgt_pkg::dma_reg_req_t dma_req_q, // Sampled DMA access
  output logic [7:0] initiator_cbe_n_q // Lanes to drive
);
  import pci_tgt_pkg::*;

  // Level driven, so the backend clears its source to release the pin
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      inta_oe_q <= 1'b0;
    end else begin
      inta_oe_q <= int_enable && !backend_irq_in_low;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dma_req_q <= '0;
    end else begin
      dma_req_q.rd <= !dma_reg_select_low && !dma_reg_read_low;
      dma_req_q.wr <= !dma_reg_select_low && !dma_reg_write_low;
      dma_req_q.index <= dma_reg_index;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      initiator_cbe_n_q <= cbe_idle;
    end else if (initiator_active) begin
      initiator_cbe_n_q <= {initiator_lane_enables_hi, initiator_lane_enables_lo};
    end else begin
      initiator_cbe_n_q <= cbe_idle;
    end
  end

  chk_irq_drive:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    (int_enable && !backend_irq_in_low) |=> inta_oe_q)
    else $error("Interrupt pin not pulled");

  chk_dma_strobe:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    (dma_reg_select_low || (dma_reg_read_low && dma_reg_write_low))
      |=> !dma_req_q.rd && !dma_req_q.wr)
    else $error("DMA access without strobes");

  chk_lane_drive:
  assert property (@(posedge clk_sys) disable iff (!resetn)
    initiator_active |=> initiator_cbe_n_q[3:0] == $past(initiator_lane_enables_lo))
    else $error("Lower lanes not passed");
endmodule // tgt_backend_side
`default_nettype wire

//--- verif/pci_master_model.sv
// Behavioural PCI bus master: address phase, data beats, stop handling.
// Assumes the target registers its control pins on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module pci_master_model (
  input wire logic clk_sys, // Bus clock
  input wire pci_tgt_pkg::tgt_ctl_t ctl_out, // Target control
  input wire logic [31:0] ad_out, // Read data
  output var pci_tgt_pkg::bus_in_t bus_in // Master pins
);
  import pci_tgt_pkg::*;
  int beats;
  logic claimed, stopped, abort;
  logic hung = 1'b0;
  logic [31:0] rdat;
  logic [3:0] lanes = 4'h0;
  initial bus_in = '{1'b1, 1'b1, 1'b0, 4'hF, 32'h0000_0000};
  // Pins change on the falling edge only
  task automatic run(input logic [3:0] cmd, input logic [31:0] a, input logic sel,
                     input int n, input logic [31:0] wd);
    bit fin;
    beats = 0;
    claimed = 0;
    stopped = 0;
    abort = 0;
    fin = 0;
    @(negedge clk_sys);
    bus_in = '{1'b0, 1'b1, sel, cmd, a};
    @(negedge clk_sys);
    // Read: lines released, show the inverse so no stale value looks valid
    bus_in = '{n < 2, 1'b0, 1'b0, lanes, cmd[0] ? wd : ~a};
    for (int i = 0; i < 40 && !fin; i++) begin
      @(posedge clk_sys);
      if (!ctl_out.devsel_n) claimed = 1'b1;
      if (claimed && ctl_out.devsel_n && !ctl_out.stop_n) abort = 1'b1;
      if (!ctl_out.stop_n) stopped = 1'b1;
      if (!ctl_out.trdy_n) rdat = ad_out;
      if (!ctl_out.trdy_n) beats++;
      fin = bus_in.frame_n && (!ctl_out.trdy_n || stopped);
      if (i == 5 && !claimed) fin = 1;
      @(negedge clk_sys);
      bus_in.frame_n = stopped || beats >= n - 1;
      bus_in.ad = cmd[0] ? wd + beats : ~bus_in.ad;
    end
    // Loop bound used up without an end: the bench counts it as a failure
    hung = !fin;
    bus_in = '{1'b1, 1'b1, 1'b0, 4'hF, ~bus_in.ad};
    repeat (3) @(negedge clk_sys);
  endtask
endmodule // pci_master_model
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the PCI target control block.
// Assumes the master model drives the bus; backend driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pci_tgt_pkg::*;
  localparam logic [31:0] mb = 32'h0040_0000;
  localparam logic [31:0] ib = 32'h0000_1000;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  bus_in_t bus_in;
  tgt_ctl_t ctl_out;
  cycle_qual_t cq;
  dma_reg_req_t dma_req;
  logic ctl_oe, ad_oe, inta_out, inta_oe, dp_b, dp_e, rd_taken, oe_seen;
  logic mem_en = 1, io_en = 1, int_en = 0, init_act = 0, busy = 0, err = 0;
  logic wrdy = 1, rrdy = 1, irq_n = 1, sel_n = 1, rd_n = 1, wr_n = 1;
  logic [1:0] idx = 2'h0;
  logic [3:0] lo = 4'hF, hi = 4'hF, wstb, lastb;
  logic [7:0] icbe;
  logic [31:0] rdd = 32'h0000_0000, ad_out, beat_addr, wr_data, lastw;
  int miscompares = 0, total_checks = 0, nwr = 0, nbeg = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (dp_b === 1'b1) nbeg++;
    if (wstb !== 4'h0) nwr++;
    if (wstb !== 4'h0) lastw = wr_data;
    if (wstb !== 4'h0) lastb = wstb;
    if (ctl_out.trdy_n === 1'b0) oe_seen = ad_oe;
  end
  pci_target_command_backend_ctrl u_pci_target_command_backend_ctrl (.clk_sys(clk_sys),
    .resetn(resetn), .bus_in(bus_in), .mem_space_en(mem_en), .io_space_en(io_en),
    .int_enable(int_en), .mem_base(mb), .io_base(ib), .initiator_active(init_act),
    .backend_busy(busy), .backend_error(err), .backend_write_ready(wrdy),
    .backend_read_ready(rrdy), .rd_data(rdd), .backend_irq_in_low(irq_n),
    .dma_reg_select_low(sel_n), .dma_reg_read_low(rd_n), .dma_reg_write_low(wr_n),
    .dma_reg_index(idx), .initiator_lane_enables_lo(lo), .initiator_lane_enables_hi(hi),
    .ctl_out(ctl_out), .ctl_oe(ctl_oe), .ad_out(ad_out), .ad_oe(ad_oe),
    .inta_out(inta_out), .inta_oe(inta_oe), .datapath_begin(dp_b), .datapath_end(dp_e),
    .cycle_qual(cq), .beat_addr(beat_addr), .wr_data(wr_data), .wr_lane_strobe(wstb),
    .rd_taken(rd_taken), .dma_req(dma_req), .initiator_cbe_n(icbe));
  pci_master_model u_pci_master_model (.clk_sys(clk_sys), .ctl_out(ctl_out),
    .ad_out(ad_out), .bus_in(bus_in));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic go(input logic [3:0] c, input logic [31:0] a, input logic s, input int n);
    u_pci_master_model.run(c, a, s, n, 32'hC0DE_0000);
    if (u_pci_master_model.hung !== 1'b0) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic t_reset();
    check("ctl", ctl_out, 3'h7);
    check("ctl_oe", ctl_oe, 0);
    check("icbe", icbe, 8'hFF);
    check("inta_oe", inta_oe, 0);
  endtask
  task automatic t_mem_read();
    logic [3:0] cl[3] = '{cmd_mem_rd, cmd_mem_rd_mult, cmd_mem_rd_line};
    foreach (cl[i]) begin
      nbeg = 0;
      rdd = 32'h1234_0000 + cl[i];
      go(cl[i], mb + 32'h0000_0010, 0, 1);
      check("rd claim", u_pci_master_model.claimed, 1);
      check("rd beats", u_pci_master_model.beats, 1);
      check("rd data", u_pci_master_model.rdat, rdd);
      check("rd begin", nbeg, 1);
      check("rd qual", {cq.is_read, cq.addr[30:0]}, {1'b1, mb[30:0] + 31'h0000_0010});
      check("rd oe", oe_seen, 1);
      check("rd addr", beat_addr, mb + 32'h0000_0014);
    end
  endtask
  task automatic t_burst_write();
    nwr = 0;
    u_pci_master_model.lanes = 4'h5;
    go(cmd_mem_wr, mb + 32'h0000_0100, 0, 3);
    check("wr beats", u_pci_master_model.beats, 3);
    check("wr count", nwr, 3);
    check("wr data", lastw, 32'hC0DE_0002);
    check("wr lanes", lastb, 4'hA);
    check("wr oe", oe_seen, 0);
    check("wr addr", beat_addr, mb + 32'h0000_010C);
    nwr = 0;
    go(cmd_io_wr, ib + 32'h0000_00FC, 0, 1);
    check("io wr", {nwr[3:0], lastb}, {4'h1, 4'hA});
    u_pci_master_model.lanes = 4'h0;
  endtask
  task automatic t_refuse();
    logic [3:0] cl[8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hD, 4'hF};
    foreach (cl[i]) begin
      go(cl[i], mb, 0, 1);
      check("bad cmd", u_pci_master_model.claimed, 0);
    end
    go(cmd_mem_rd, mb + 32'h0040_0000, 0, 1);
    check("mem miss", u_pci_master_model.claimed, 0);
    go(cmd_io_rd, ib + 32'h0000_0100, 0, 1);
    check("io miss", u_pci_master_model.claimed, 0);
    mem_en = 0;
    go(cmd_mem_rd, mb, 0, 1);
    check("mem off", u_pci_master_model.claimed, 0);
    mem_en = 1;
    io_en = 0;
    go(cmd_io_rd, ib, 0, 1);
    check("io off", u_pci_master_model.claimed, 0);
    io_en = 1;
    go(cmd_io_rd, ib + 32'h0000_0004, 0, 1);
    check("io rd", {u_pci_master_model.claimed, cq.is_io}, 2'h3);
  endtask
  task automatic t_cfg();
    // Function number field 10:8 kept at zero
    go(cmd_cfg_rd, 32'hFFFF_F8A4, 1, 1);
    check("cfg hit", {u_pci_master_model.claimed, cq.is_cfg}, 2'h3);
    check("cfg idx", cq.cfg_index, 6'h29);
    go(cmd_cfg_wr, 32'h0000_00A4, 0, 1);
    check("cfg nosel", u_pci_master_model.claimed, 0);
    go(cmd_cfg_rd, 32'h0000_00A5, 1, 1);
    check("cfg type", u_pci_master_model.claimed, 0);
  endtask
  task automatic t_stops();
    busy = 1;
    go(cmd_mem_rd, mb, 0, 2);
    check("retry", {u_pci_master_model.stopped, u_pci_master_model.beats[3:0]}, 5'h10);
    busy = 0;
    fork
      go(cmd_mem_rd, mb, 0, 6);
      begin
        for (int i = 0; i < 40 && rd_taken !== 1'b1; i++) @(posedge clk_sys);
        if (rd_taken !== 1'b1) begin
          miscompares++;
          end_of_test();
        end
        @(negedge clk_sys);
        busy = 1;
      end
    join
    busy = 0;
    check("disc", u_pci_master_model.stopped && u_pci_master_model.beats inside {[1:5]}, 1);
    err = 1;
    go(cmd_mem_rd, mb, 0, 1);
    check("abort", {u_pci_master_model.abort, u_pci_master_model.beats[3:0]}, 5'h10);
    err = 0;
    wrdy = 0;
    go(cmd_mem_wr, mb, 0, 1);
    check("no wrdy", {u_pci_master_model.stopped, u_pci_master_model.beats[3:0]}, 5'h10);
    wrdy = 1;
  endtask
  task automatic t_side();
    init_act = 1;
    busy = 1;
    err = 1;
    lo = 4'h3;
    hi = 4'hC;
    int_en = 1;
    irq_n = 0;
    sel_n = 0;
    rd_n = 0;
    idx = 2'h2;
    go(cmd_mem_rd, mb, 0, 1);
    check("init claim", u_pci_master_model.claimed, 0);
    check("icbe", icbe, 8'hC3);
    check("irq", inta_oe, 1);
    check("irq lvl", inta_out, 0);
    check("dma rd", dma_req, 4'hA);
    {init_act, busy, err, int_en, rd_n, wr_n, idx} = 8'h09;
    @(negedge clk_sys);
    check("icbe off", icbe, 8'hFF);
    check("irq off", inta_oe, 0);
    check("dma wr", dma_req, 4'h5);
    {irq_n, sel_n, wr_n} = 3'h7;
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    resetn = 1;
    @(negedge clk_sys);
    t_reset();
    t_mem_read();
    t_burst_write();
    t_refuse();
    t_cfg();
    t_stops();
    t_side();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
